// file: include/limit_pkg.sv
// Purpose: shared constants, types and helpers for the limit switch evaluator
// Assumes: measurement values arrive as signed fixed point in base units
// Notes:   scale factors are unsigned q16.16, one entry per source and unit
package limit_pkg;

	localparam int NUM_LIMITS  = 4;
	localparam int IDX_W       = 2;
	localparam int VAL_W       = 32;
	localparam int UNIT_W      = 4;
	localparam int SRC_W       = 3;
	localparam int FRAC_W      = 16;
	localparam int PROD_W      = 2 * VAL_W;
	localparam int SCALE_AW    = SRC_W + UNIT_W;
	localparam int SCALE_DEPTH = 1 << SCALE_AW;
	localparam logic [VAL_W-1:0] SCALE_ONE = 32'h0001_0000;

	typedef enum logic [SRC_W-1:0] {
		SRC_LOAD   = 3'h0,
		SRC_PEAK   = 3'h1,
		SRC_VALLEY = 3'h2,
		SRC_POS    = 3'h3,
		SRC_VEL    = 3'h4,
		SRC_AVG    = 3'h5
	} source_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EDIT  = 2'b01,
		ST_APPLY = 2'b11
	} setup_st_t;

	typedef struct packed {
		logic                    enable;
		logic                    nclosed;
		source_t                 source;
		logic [UNIT_W-1:0]       unit;
		logic signed [VAL_W-1:0] set_pt;
		logic signed [VAL_W-1:0] rst_pt;
		logic                    trip_gt;
		logic                    latch;
	} limit_cfg_t;

	localparam limit_cfg_t CFG_RESET = '{
		enable:  1'b0,
		nclosed: 1'b0,
		source:  SRC_LOAD,
		unit:    4'h0,
		set_pt:  32'h0000_0000,
		rst_pt:  32'h0000_0000,
		trip_gt: 1'b1,
		latch:   1'b0
	};

	// load-derived sources need a usable cell, encoder sources a nonzero cpi
	function automatic logic src_err(
		input source_t s,
		input logic    cell_cal,
		input logic    rating_zero,
		input logic    mvv_zero,
		input logic    cpi_zero,
		input logic    avg_opt
	);
		logic load_bad;
		load_bad = !cell_cal || rating_zero || mvv_zero;
		unique case (s)
			SRC_LOAD, SRC_PEAK, SRC_VALLEY: src_err = load_bad;
			SRC_AVG:                        src_err = load_bad || !avg_opt;
			SRC_POS, SRC_VEL:               src_err = cpi_zero;
			default:                        src_err = 1'b1;
		endcase
	endfunction

	function automatic logic [SCALE_AW-1:0] scale_index(
		input source_t           s,
		input logic [UNIT_W-1:0] u
	);
		scale_index = {s, u};
	endfunction

endpackage

// file: include/limit_ch_if.sv
// Purpose: carries one limit's settings and results between top and channel
// Assumes: single clock domain
// Notes:   value is already expressed in the limit's chosen unit
`timescale 1ns/100ps
`default_nettype none
interface limit_ch_if;
	import limit_pkg::*;

	logic                    enable;
	logic                    trip_gt;
	logic                    latch;
	logic signed [VAL_W-1:0] set_pt;
	logic signed [VAL_W-1:0] rst_pt;
	logic signed [VAL_W-1:0] value;
	logic                    value_vld;
	logic                    src_bad;
	logic                    man_rst;
	logic                    active;
	logic                    err;

	modport host (
		output enable, trip_gt, latch, set_pt, rst_pt, value, value_vld,
		output src_bad, man_rst,
		input  active, err
	);

	modport chan (
		input  enable, trip_gt, latch, set_pt, rst_pt, value, value_vld,
		input  src_bad, man_rst,
		output active, err
	);
endinterface
`default_nettype wire

// file: hw/limit_scale.sv
// Purpose: converts a base-unit source value into the limit's chosen unit
// Assumes: factor is unsigned q16.16
// Notes:   one cycle of latency; result truncates toward minus infinity
`timescale 1ns/100ps
`default_nettype none
module limit_scale
	import limit_pkg::*;
(
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic signed [VAL_W-1:0] value_i,
	input  wire logic        [VAL_W-1:0] factor_i,
	input  wire logic                    vld_i,
	output logic signed      [VAL_W-1:0] value_o,
	output logic                         vld_o
);
	logic signed [PROD_W-1:0] prod;
	logic signed [VAL_W-1:0]  value_nxt;

	always_comb begin
		// factor is widened with a zero sign bit so it stays positive
		prod      = PROD_W'(value_i * $signed({1'b0, factor_i}));
		value_nxt = prod[FRAC_W +: VAL_W];
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			value_o <= '0;
			vld_o   <= 1'b0;
		end else begin
			value_o <= value_nxt;
			vld_o   <= vld_i;
		end
	end
endmodule
`default_nettype wire

// file: hw/limit_channel.sv
// Purpose: activation state of one limit
// Assumes: settings are stable between committed setups
// Notes:   manual reset also clears a non-latching limit
`timescale 1ns/100ps
`default_nettype none
module limit_channel
	import limit_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	limit_ch_if.chan  ch
);
	logic active_r;
	logic active_nxt;
	logic err_r;
	logic err_nxt;
	logic set_c;
	logic rst_c;

	always_comb begin
		set_c = ch.trip_gt ? (ch.value > ch.set_pt)
		                   : (ch.value < ch.set_pt);
		if (ch.latch) begin
			rst_c = ch.man_rst;
		end else begin
			rst_c = ch.man_rst || (ch.trip_gt ? (ch.value < ch.rst_pt)
			                                  : (ch.value > ch.rst_pt));
		end
		active_nxt = active_r;
		err_nxt    = ch.enable && ch.src_bad;
		if (!ch.enable || ch.src_bad) begin
			active_nxt = 1'b0;
		end else if (ch.value_vld) begin
			// both tests are made every time; reset wins
			if (rst_c) begin
				active_nxt = 1'b0;
			end else if (set_c) begin
				active_nxt = 1'b1;
			end
		end else if (ch.man_rst) begin
			active_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active_r <= 1'b0;
			err_r    <= 1'b0;
		end else begin
			active_r <= active_nxt;
			err_r    <= err_nxt;
		end
	end

	assign ch.active = active_r;
	assign ch.err    = err_r;
endmodule
`default_nettype wire

// file: hw/limit_switch_evaluator.sv
// Purpose: four configurable limit contacts driven from measurement sources
// Assumes: front end supplies base-unit values and sensor health flags
// Notes:   setup edits a shadow copy; only a completed setup touches a limit
//
// How it works
// - four independent limits, chosen by an index for one to four.
// - polarity picks the idle contact level; active drives the opposite.
// - a disabled limit sits at its normal contact, ignoring the source.
// - source is load, peak, valley, position, velocity or optional average.
// - set and reset points compare against the source in the chosen unit.
// - greater-than limits activate when the source exceeds the set point.
// - less-than limits activate when the source drops below the set point.
// - latched limits stay active until manual reset; reset point ignored.
// - unlatched limits release when the source passes the reset point.
// - set and reset are tested separately; reset wins when both hold.
// - a source error forces an enabled limit off while it lasts.
// - load sources fail without a good cell; position needs nonzero cpi.
// - an enabled limit with a bad source reports an error marker.
// - new settings apply only on completed setup; abort keeps the old ones.
`timescale 1ns/100ps
`default_nettype none
module limit_switch_evaluator
	import limit_pkg::*;
(
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic signed [VAL_W-1:0] load_val_i,
	input  wire logic signed [VAL_W-1:0] peak_val_i,
	input  wire logic signed [VAL_W-1:0] valley_val_i,
	input  wire logic signed [VAL_W-1:0] pos_val_i,
	input  wire logic signed [VAL_W-1:0] vel_val_i,
	input  wire logic signed [VAL_W-1:0] avg_val_i,
	input  wire logic                    meas_vld_i,
	input  wire logic                    cell_cal_i,
	input  wire logic                    cell_rating_zero_i,
	input  wire logic                    mvv_zero_i,
	input  wire logic                    cpi_zero_i,
	input  wire logic                    avg_opt_i,
	input  wire logic                    setup_start_i,
	input  wire logic [IDX_W-1:0]        setup_sel_i,
	input  wire logic                    setup_wr_i,
	input  wire logic                    setup_done_i,
	input  wire logic                    setup_abort_i,
	input  wire logic                    cfg_nclosed_i,
	input  wire logic                    cfg_enable_i,
	input  wire logic [SRC_W-1:0]        cfg_source_i,
	input  wire logic [UNIT_W-1:0]       cfg_unit_i,
	input  wire logic signed [VAL_W-1:0] cfg_set_pt_i,
	input  wire logic                    cfg_trip_gt_i,
	input  wire logic                    cfg_latch_i,
	input  wire logic signed [VAL_W-1:0] cfg_rst_pt_i,
	input  wire logic [NUM_LIMITS-1:0]   man_reset_i,
	input  wire logic                    scale_we_i,
	input  wire logic [SCALE_AW-1:0]     scale_addr_i,
	input  wire logic [VAL_W-1:0]        scale_data_i,
	output logic [NUM_LIMITS-1:0]        contact_o,
	output logic [NUM_LIMITS-1:0]        active_o,
	output logic [NUM_LIMITS-1:0]        err_o,
	output logic                         setup_busy_o
);
	// setup sequence state
	setup_st_t            st_r;
	setup_st_t            st_nxt;
	logic [IDX_W-1:0]     sel_r;
	logic [IDX_W-1:0]     sel_nxt;
	limit_cfg_t           shadow_r;
	limit_cfg_t           shadow_nxt;
	logic                 busy_r;
	logic                 busy_nxt;

	// committed settings of every limit
	limit_cfg_t           cfg_r   [NUM_LIMITS];
	limit_cfg_t           cfg_nxt [NUM_LIMITS];

	// unit conversion factors
	logic [VAL_W-1:0]     scale_r   [SCALE_DEPTH];
	logic [VAL_W-1:0]     scale_nxt [SCALE_DEPTH];

	// registered outputs
	logic [NUM_LIMITS-1:0] contact_r;
	logic [NUM_LIMITS-1:0] contact_nxt;
	logic [NUM_LIMITS-1:0] active_r;
	logic [NUM_LIMITS-1:0] active_nxt;
	logic [NUM_LIMITS-1:0] err_r;
	logic [NUM_LIMITS-1:0] err_nxt;

	// per-limit datapath
	logic signed [VAL_W-1:0] raw_val   [NUM_LIMITS];
	logic [VAL_W-1:0]        factor    [NUM_LIMITS];
	logic [NUM_LIMITS-1:0]   src_bad;
	logic [NUM_LIMITS-1:0]   ch_active;
	logic [NUM_LIMITS-1:0]   ch_err;

	// one interface per limit keeps the four channels strictly apart
	limit_ch_if ch [NUM_LIMITS] ();

	// illegal codes read as zero; their error flag forces the limit off
	function automatic logic signed [VAL_W-1:0] pick_source(
		input source_t                 s,
		input logic signed [VAL_W-1:0] load_v,
		input logic signed [VAL_W-1:0] peak_v,
		input logic signed [VAL_W-1:0] valley_v,
		input logic signed [VAL_W-1:0] pos_v,
		input logic signed [VAL_W-1:0] vel_v,
		input logic signed [VAL_W-1:0] avg_v
	);
		unique case (s)
			SRC_LOAD:   pick_source = load_v;
			SRC_PEAK:   pick_source = peak_v;
			SRC_VALLEY: pick_source = valley_v;
			SRC_POS:    pick_source = pos_v;
			SRC_VEL:    pick_source = vel_v;
			SRC_AVG:    pick_source = avg_v;
			default:    pick_source = '0;
		endcase
	endfunction

	// contact level seen outside for a given activation state
	function automatic logic contact_level(
		input logic nclosed,
		input logic active
	);
		contact_level = nclosed ^ active;
	endfunction

	// setup sequence
	always_comb begin
		st_nxt     = st_r;
		sel_nxt    = sel_r;
		shadow_nxt = shadow_r;
		unique case (st_r)
			ST_IDLE: begin
				if (setup_start_i) begin
					// edit starts from the limit's present settings
					sel_nxt    = setup_sel_i;
					shadow_nxt = cfg_r[setup_sel_i];
					st_nxt     = ST_EDIT;
				end
			end
			ST_EDIT: begin
				// abort first: a late done must not commit a dropped edit
				if (setup_abort_i) begin
					st_nxt = ST_IDLE;
				end else if (setup_done_i) begin
					st_nxt = ST_APPLY;
				end else if (setup_wr_i) begin
					shadow_nxt.nclosed = cfg_nclosed_i;
					shadow_nxt.enable  = cfg_enable_i;
					shadow_nxt.source  = source_t'(cfg_source_i);
					shadow_nxt.unit    = cfg_unit_i;
					shadow_nxt.set_pt  = cfg_set_pt_i;
					shadow_nxt.trip_gt = cfg_trip_gt_i;
					shadow_nxt.latch   = cfg_latch_i;
					shadow_nxt.rst_pt  = cfg_rst_pt_i;
				end
			end
			ST_APPLY: begin
				st_nxt = ST_IDLE;
			end
			// an upset code means nothing; fall back without committing
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		// registered so the busy pin is a flop with the state's timing
		busy_nxt = (st_nxt != ST_IDLE);
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r     <= ST_IDLE;
			sel_r    <= '0;
			shadow_r <= CFG_RESET;
			busy_r   <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			sel_r    <= sel_nxt;
			shadow_r <= shadow_nxt;
			busy_r   <= busy_nxt;
		end
	end

	// committed settings change only in the apply state
	always_comb begin
		for (int i = 0; i < NUM_LIMITS; i++) begin
			cfg_nxt[i] = cfg_r[i];
			if (st_r == ST_APPLY && sel_r == IDX_W'(i)) begin
				cfg_nxt[i] = shadow_r;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < NUM_LIMITS; i++) begin
				cfg_r[i] <= CFG_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_LIMITS; i++) begin
				cfg_r[i] <= cfg_nxt[i];
			end
		end
	end

	// factor table; unity until the front end loads real factors
	always_comb begin
		for (int a = 0; a < SCALE_DEPTH; a++) begin
			scale_nxt[a] = scale_r[a];
		end
		if (scale_we_i) begin
			scale_nxt[scale_addr_i] = scale_data_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int a = 0; a < SCALE_DEPTH; a++) begin
				scale_r[a] <= SCALE_ONE;
			end
		end else begin
			for (int a = 0; a < SCALE_DEPTH; a++) begin
				scale_r[a] <= scale_nxt[a];
			end
		end
	end

	// source selection and health per limit
	always_comb begin
		for (int i = 0; i < NUM_LIMITS; i++) begin
			raw_val[i] = pick_source(cfg_r[i].source, load_val_i,
				peak_val_i, valley_val_i, pos_val_i, vel_val_i,
				avg_val_i);
			factor[i]  = scale_r[scale_index(cfg_r[i].source,
			                                 cfg_r[i].unit)];
			src_bad[i] = src_err(cfg_r[i].source, cell_cal_i,
			                     cell_rating_zero_i, mvv_zero_i,
			                     cpi_zero_i, avg_opt_i);
		end
	end

	// the scaler adds one cycle, so the channel sees value and valid together
	for (genvar g = 0; g < NUM_LIMITS; g++) begin : g_lim
		limit_scale u_scale (
			.core_clk_i (core_clk_i),
			.rst_n_i    (rst_n_i),
			.value_i    (raw_val[g]),
			.factor_i   (factor[g]),
			.vld_i      (meas_vld_i),
			.value_o    (ch[g].value),
			.vld_o      (ch[g].value_vld)
		);

		assign ch[g].enable  = cfg_r[g].enable;
		assign ch[g].trip_gt = cfg_r[g].trip_gt;
		assign ch[g].latch   = cfg_r[g].latch;
		assign ch[g].set_pt  = cfg_r[g].set_pt;
		assign ch[g].rst_pt  = cfg_r[g].rst_pt;
		assign ch[g].src_bad = src_bad[g];
		assign ch[g].man_rst = man_reset_i[g];
		assign ch_active[g]  = ch[g].active;
		assign ch_err[g]     = ch[g].err;

		limit_channel u_chan (
			.core_clk_i (core_clk_i),
			.rst_n_i    (rst_n_i),
			.ch         (ch[g])
		);
	end

	// contact level follows polarity; costs one cycle so outputs are flops
	always_comb begin
		for (int i = 0; i < NUM_LIMITS; i++) begin
			contact_nxt[i] = contact_level(cfg_r[i].nclosed,
				ch_active[i]);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			contact_r <= '0;
		end else begin
			contact_r <= contact_nxt;
		end
	end

	// status trails the channels by the same cycle as the contacts
	always_comb begin
		active_nxt = ch_active;
		err_nxt    = ch_err;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active_r <= '0;
			err_r    <= '0;
		end else begin
			active_r <= active_nxt;
			err_r    <= err_nxt;
		end
	end

	assign contact_o    = contact_r;
	assign active_o     = active_r;
	assign err_o        = err_r;
	assign setup_busy_o = busy_r;
endmodule
`default_nettype wire

// file: bench/limit_switch_evaluator_checker.sv
// Purpose: port-level checks on the limit switch evaluator
// Assumes: one clock, asynchronous active-low reset
// Notes:   only top ports are visible, so config is inferred from timing
`timescale 1ns/100ps
`default_nettype none
module limit_switch_evaluator_checker
	import limit_pkg::*;
(
	input wire logic                  core_clk_i,
	input wire logic                  rst_n_i,
	input wire logic                  meas_vld_i,
	input wire logic                  setup_start_i,
	input wire logic                  setup_done_i,
	input wire logic                  setup_abort_i,
	input wire logic [NUM_LIMITS-1:0] man_reset_i,
	input wire logic [NUM_LIMITS-1:0] contact_o,
	input wire logic [NUM_LIMITS-1:0] active_o,
	input wire logic [NUM_LIMITS-1:0] err_o,
	input wire logic                  setup_busy_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_reset_quiet: assert property ($rose(rst_n_i) |->
		!(|{active_o, contact_o, err_o, setup_busy_o}))
		else $error("outputs not idle after reset");
	a_err_off: assert property ((err_o & active_o) == '0)
		else $error("limit active while in error");
	a_rise_sample: assert property (
		(|(active_o & ~$past(active_o))) |-> $past(meas_vld_i, 3))
		else $error("activation without a sample");
	a_manual_clear: assert property (
		man_reset_i[2] |-> ##[1:3] !active_o[2])
		else $error("manual reset did not clear");
	a_start_busy: assert property (
		setup_start_i && !setup_busy_o |=> setup_busy_o)
		else $error("setup start not taken");
	a_abort_idle: assert property (
		setup_abort_i && setup_busy_o |=> !setup_busy_o)
		else $error("abort did not end setup");
	a_done_apply: assert property (
		setup_done_i && setup_busy_o ##1 !setup_start_i |-> ##1 !setup_busy_o)
		else $error("setup did not complete");
	// contact may only move with activation or a committed setup
	a_contact_cause: assert property ($changed(contact_o) |->
		$changed(active_o) || $past(setup_busy_o, 2) || $past(setup_busy_o, 3))
		else $error("contact changed without cause");

	c_latch_set: cover property ($rose(active_o[2]));
	c_err_seen: cover property ($rose(err_o[0]));
	c_abort: cover property (setup_abort_i && setup_busy_o);
endmodule
`default_nettype wire

// file: bench/meas_src_model.sv
// Purpose: measurement front end feeding one value to every source
// Assumes: value is meaningful only in the valid cycle
// Notes:   bus toggles between samples so ignoring valid gets caught
`timescale 1ns/100ps
`default_nettype none
module meas_src_model
	import limit_pkg::*;
(
	input  wire logic                    core_clk_i,
	input  wire logic                    go_i,
	input  wire logic signed [VAL_W-1:0] val_i,
	output logic signed      [VAL_W-1:0] val_o,
	output logic                         vld_o
);
	initial val_o = '0;
	initial vld_o = 1'b0;
	always @(posedge core_clk_i) begin
		vld_o <= go_i;
		val_o <= go_i ? val_i : ~val_o;
	end
endmodule
`default_nettype wire

// file: bench/limit_switch_evaluator_tb.sv
// Purpose: directed tests of the four limit channels
// Assumes: 200 MHz clock, inputs moved 1 ns after the rising edge
// Notes:   one measurement value drives all sources at once
`timescale 1ns/100ps
`default_nettype none
module limit_switch_evaluator_tb;
	import limit_pkg::*;
	logic              clk = 1'b0;
	logic              rst_n, go, st, wr, dn, ab, swe;
	logic              cal, rz, mz, cz, avg, en, nc, gt, lat, busy;
	logic              vld;
	logic [1:0]        sel;
	logic [2:0]        src;
	logic [3:0]        unit, mr, contact, active, err, ncm;
	logic [6:0]        sa;
	logic [31:0]       sd;
	logic signed [31:0] v, pv, setp, rstp;
	int                error_cnt = 0;
	int                n_tests = 0;
	int                i;
	int                sv[4] = '{100, 60, -10, 100};
	logic [3:0]        ea[4] = '{4'h3, 4'h1, 4'h4, 4'h7};
	logic [3:0]        bad[4] = '{4'h0, 4'hC, 4'hA, 4'h9};
	logic [3:0]        ee[4] = '{4'h1, 4'h1, 4'h1, 4'h6};

	always #2.5 clk = ~clk;

	meas_src_model meas_src_model_inst (.core_clk_i(clk), .go_i(go),
		.val_i(v), .val_o(pv), .vld_o(vld));

	limit_switch_evaluator limit_switch_evaluator_inst (
		.core_clk_i(clk), .rst_n_i(rst_n), .load_val_i(pv),
		.peak_val_i(pv), .valley_val_i(pv), .pos_val_i(pv),
		.vel_val_i(pv), .avg_val_i(pv), .meas_vld_i(vld),
		.cell_cal_i(cal), .cell_rating_zero_i(rz), .mvv_zero_i(mz),
		.cpi_zero_i(cz), .avg_opt_i(avg), .setup_start_i(st),
		.setup_sel_i(sel), .setup_wr_i(wr), .setup_done_i(dn),
		.setup_abort_i(ab), .cfg_nclosed_i(nc), .cfg_enable_i(en),
		.cfg_source_i(src), .cfg_unit_i(unit), .cfg_set_pt_i(setp),
		.cfg_trip_gt_i(gt), .cfg_latch_i(lat), .cfg_rst_pt_i(rstp),
		.man_reset_i(mr), .scale_we_i(swe), .scale_addr_i(sa),
		.scale_data_i(sd), .contact_o(contact), .active_o(active),
		.err_o(err), .setup_busy_o(busy));

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// bounded wait; a hung setup ends the run
	task automatic wait_busy(input logic b);
		int n;
		for (n = 0; n < 8 && busy !== b; n++)
			tick;
		if (busy !== b) begin
			error_cnt++;
			summarize;
		end
	endtask

	// f = {enable, nclosed, trip_gt, latch}
	task automatic setup(input logic [1:0] k, input logic [3:0] f,
		input logic [2:0] s, input logic [3:0] u, input int sp,
		input int rp, input logic abort);
		sel = k;
		st = 1'b1;
		tick;
		st = 1'b0;
		wait_busy(1'b1);
		{en, nc, gt, lat} = f;
		src = s;
		unit = u;
		setp = sp;
		rstp = rp;
		wr = 1'b1;
		tick;
		wr = 1'b0;
		dn = !abort;
		ab = abort;
		tick;
		dn = 1'b0;
		ab = 1'b0;
		wait_busy(1'b0);
		repeat (3) tick;
	endtask

	// partner needs one edge, then sample plus three edges of latency
	task automatic samp(input int x);
		v = x;
		go = 1'b1;
		tick;
		go = 1'b0;
		repeat (6) tick;
	endtask

	initial begin
		{rst_n, go, st, wr, dn, ab, swe, rz, mz, cz} = '0;
		{en, nc, gt, lat, sel, src, unit, mr, sa, sd, v} = '0;
		{setp, rstp} = '0;
		cal = 1'b1;
		avg = 1'b1;
		repeat (5) tick;
		rst_n = 1'b1;
		chk(active, 4'h0);
		chk(contact, 4'h0);
		chk(err, 4'h0);
		$display("test reset done");

		setup(2'd0, 4'hA, SRC_VALLEY, 4'h0, 50, 20, 1'b0);
		setup(2'd1, 4'hE, SRC_VEL, 4'h0, 50, 80, 1'b0);
		setup(2'd2, 4'h9, SRC_POS, 4'h0, 0, 40, 1'b0);
		setup(2'd3, 4'h6, SRC_PEAK, 4'h0, 0, 0, 1'b0);
		ncm = 4'hA;
		chk(contact, ncm);
		for (i = 0; i < 4; i++) begin
			samp(sv[i]);
			chk(active, ea[i]);
			chk(contact, ea[i] ^ ncm);
		end
		mr = 4'h4;
		tick;
		mr = 4'h0;
		repeat (3) tick;
		chk(active, 4'h3);
		$display("test compare done");

		for (i = 0; i < 4; i++) begin
			{cal, rz, mz, cz} = bad[i];
			repeat (3) tick;
			chk(err, ee[i]);
			chk(active, 4'h2 & ~ee[i]);
		end
		{cal, rz, mz, cz} = 4'h8;
		repeat (3) tick;
		chk(err, 4'h0);
		avg = 1'b0;
		setup(2'd1, 4'hE, SRC_AVG, 4'h0, 50, 80, 1'b0);
		chk(err, 4'h2);
		avg = 1'b1;
		repeat (3) tick;
		chk(err, 4'h0);
		$display("test error done");

		setup(2'd3, 4'hA, SRC_LOAD, 4'h0, -1000, 0, 1'b1);
		samp(100);
		chk(active, 4'h3);
		chk(contact, 4'h9);
		sa = {SRC_LOAD, 4'h2};
		sd = 32'h0002_0000;
		swe = 1'b1;
		tick;
		swe = 1'b0;
		setup(2'd3, 4'hA, SRC_LOAD, 4'h2, 150, 0, 1'b0);
		samp(100);
		chk(active, 4'hB);
		chk(contact, 4'h9);
		$display("test setup done");
		setup(2'd2, 4'h8, SRC_POS, 4'h0, 0, 40, 1'b0);
		samp(-10);
		chk(active, 4'h4);
		chk(contact, 4'h6);
		samp(50);
		chk(active, 4'h0);
		setup(2'd3, 4'hA, 3'h7, 4'h0, 0, 0, 1'b0);
		chk(err, 4'h8);
		chk(contact, 4'h2);
		$display("test release done");
		summarize;
	end
endmodule

bind limit_switch_evaluator limit_switch_evaluator_checker
	limit_switch_evaluator_checker_inst (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .meas_vld_i(meas_vld_i),
	.setup_start_i(setup_start_i), .setup_done_i(setup_done_i),
	.setup_abort_i(setup_abort_i), .man_reset_i(man_reset_i),
	.contact_o(contact_o), .active_o(active_o), .err_o(err_o),
	.setup_busy_o(setup_busy_o));
`default_nettype wire
